// [fifo_pkg.sv]
package fifo_pkg;
  localparam int              DATA_W      = 36;
  localparam int              DEPTH       = 256;
  localparam int              PTR_W       = 8;
  localparam int              CNT_W       = 9;
  localparam int              BYTE_W      = 9;
  localparam int              WORD_W      = 18;
  localparam logic [CNT_W-1:0] DEPTH_COUNT = 9'h100;
  // preset threshold values
  localparam logic [PTR_W-1:0] PRESET_8    = 8'h08;
  localparam logic [PTR_W-1:0] PRESET_16   = 8'h10;
  localparam logic [PTR_W-1:0] PRESET_64   = 8'h40;
  localparam logic [PTR_W-1:0] THR_RESET   = 8'h08;
  // offset select codes {fs1, fs0} when serial mode is not chosen
  localparam logic [1:0]       FS_PARALLEL = 2'h0;
  localparam logic [1:0]       FS_8        = 2'h1;
  localparam logic [1:0]       FS_16       = 2'h2;
  localparam logic [1:0]       FS_64       = 2'h3;
  localparam logic [4:0]       SERIAL_BITS = 5'h10;
  // cycles after reset release before strap levels are trusted
  localparam logic [2:0]       CAPTURE_WAIT = 3'h4;
  // last lane index per port B width
  localparam logic [1:0]       LAST_BYTE   = 2'h3;
  localparam logic [1:0]       LAST_WORD   = 2'h1;
  localparam logic [1:0]       LAST_LONG   = 2'h0;
  // port A synchroniser bundle layout
  localparam int              A_CLK       = 0;
  localparam int              A_SEL_N     = 1;
  localparam int              A_EN        = 2;
  localparam int              A_WR        = 3;
  localparam int              A_DATA      = 4;
  localparam int              A_SYNC_W    = 40;
  // port B synchroniser bundle layout
  localparam int              B_CLK       = 0;
  localparam int              B_SEL_N     = 1;
  localparam int              B_QUAL      = 2;
  localparam int              B_RD        = 3;
  localparam int              B_SYNC_W    = 4;
  // configuration synchroniser bundle layout
  localparam int              C_ETS       = 0;
  localparam int              C_BM        = 1;
  localparam int              C_SIZE      = 2;
  localparam int              C_SPM_N     = 3;
  localparam int              C_FS0       = 4;
  localparam int              C_FS1       = 5;
  localparam int              C_SYNC_W    = 6;

  typedef enum logic [2:0] {
    WIDTH_LONG = 3'b001,
    WIDTH_WORD = 3'b010,
    WIDTH_BYTE = 3'b100
  } width_t;

  typedef enum logic [3:0] {
    CFG_CAPTURE  = 4'b0001,
    CFG_SERIAL   = 4'b0010,
    CFG_PARALLEL = 4'b0100,
    CFG_READY    = 4'b1000
  } cfg_t;
endpackage : fifo_pkg

// [pin_sync.sv]
`timescale 1ns/1ns
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk_in,
  input  wire logic         rstn_in,
  input  wire logic [W-1:0] pins_in,
  output logic      [W-1:0] stable_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] st;
  } sync_t;

  sync_t q, d;

  // three stages; a bit settles once stages two and three agree
  always_comb begin
    d    = q;
    d.s1 = pins_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.st = (q.s2 & q.s3) | ((q.s2 ^ q.s3) & q.st);
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign stable_out = q.st;
endmodule : pin_sync

// [threshold_compare.sv]
`timescale 1ns/1ns
module threshold_compare
  import fifo_pkg::*;
(
  input  wire logic [CNT_W-1:0] level_in,
  input  wire logic [PTR_W-1:0] limit_in,
  output logic                  at_or_below_out
);
  // level compared against an offset register
  assign at_or_below_out = (level_in <= {1'b0, limit_in});
endmodule : threshold_compare

// [bus_matching_fifo.sv]
`timescale 1ns/1ns
module bus_matching_fifo
  import fifo_pkg::*;
(
  input  wire logic              mclk_in,
  input  wire logic              rstn_in,
  input  wire logic              port_a_clock_in,
  input  wire logic              port_a_select_n_in,
  input  wire logic              port_a_enable_in,
  input  wire logic              port_a_write_in,
  input  wire logic [DATA_W-1:0] port_a_bus_in,
  output logic      [DATA_W-1:0] port_a_bus_out,
  output logic                   port_a_bus_oe_out,
  input  wire logic              port_b_clock_in,
  input  wire logic              port_b_select_n_in,
  input  wire logic              port_b_qualifier_in,
  input  wire logic              port_b_read_in,
  input  wire logic [DATA_W-1:0] port_b_bus_in,
  output logic      [DATA_W-1:0] port_b_bus_out,
  output logic                   port_b_bus_oe_out,
  input  wire logic              endian_timing_select_in,
  input  wire logic              bus_match_select_in,
  input  wire logic              size_select_in,
  input  wire logic              serial_mode_n_in,
  input  wire logic [1:0]        flag_select_in,
  output logic                   empty_ready_flag_out,
  output logic                   full_space_flag_out,
  output logic                   almost_empty_flag_out,
  output logic                   almost_full_flag_out
);
  typedef struct packed {
    cfg_t              cfg;
    logic [2:0]        wait_cnt;
    width_t            width;
    logic              big_endian;
    logic [PTR_W-1:0]  low_thr;
    logic [PTR_W-1:0]  high_thr;
    logic [4:0]        serial_cnt;
    logic              par_second;
    logic              a_clk_prev;
    logic              b_clk_prev;
    logic [PTR_W-1:0]  wr_ptr;
    logic [PTR_W-1:0]  rd_ptr;
    logic [CNT_W-1:0]  mem_cnt;
    logic [DATA_W-1:0] stage_word;
    logic              staged;
    logic [1:0]        lane;
    logic [DATA_W-1:0] a_bus;
    logic              a_oe;
    logic [DATA_W-1:0] b_bus;
    logic              b_oe;
    logic              ef;
    logic              ff;
    logic              ae;
    logic              af;
  } state_t;

  state_t q, d;

  logic [DATA_W-1:0] mem_q [DEPTH];
  logic [A_SYNC_W-1:0] a_sync;
  logic [B_SYNC_W-1:0] b_sync;
  logic [C_SYNC_W-1:0] c_sync;
  logic [CNT_W-1:0]    stored_level;
  logic [CNT_W-1:0]    free_level;
  logic                low_hit;
  logic                high_hit;
  logic                wr_en;

  // every pin is brought into the mclk domain before use
  pin_sync #(.W(A_SYNC_W)) u_sync_a (
    .mclk_in    (mclk_in),
    .rstn_in    (rstn_in),
    .pins_in    ({port_a_bus_in, port_a_write_in, port_a_enable_in,
                  port_a_select_n_in, port_a_clock_in}),
    .stable_out (a_sync)
  );

  pin_sync #(.W(B_SYNC_W)) u_sync_b (
    .mclk_in    (mclk_in),
    .rstn_in    (rstn_in),
    .pins_in    ({port_b_read_in, port_b_qualifier_in,
                  port_b_select_n_in, port_b_clock_in}),
    .stable_out (b_sync)
  );

  pin_sync #(.W(C_SYNC_W)) u_sync_cfg (
    .mclk_in    (mclk_in),
    .rstn_in    (rstn_in),
    .pins_in    ({flag_select_in, serial_mode_n_in, size_select_in,
                  bus_match_select_in, endian_timing_select_in}),
    .stable_out (c_sync)
  );

  // flag comparators work on the next counts
  threshold_compare u_low_cmp (
    .level_in        (stored_level),
    .limit_in        (d.low_thr),
    .at_or_below_out (low_hit)
  );

  threshold_compare u_high_cmp (
    .level_in        (free_level),
    .limit_in        (d.high_thr),
    .at_or_below_out (high_hit)
  );

  // pick the lane of a word that port B shows next
  function automatic logic [DATA_W-1:0] lane_select(
    input logic [DATA_W-1:0] word,
    input width_t            width,
    input logic              big,
    input logic [1:0]        lane
  );
    logic [1:0] idx;
    idx = 2'h0;
    lane_select = word;
    case (width)
      WIDTH_BYTE: begin
        idx = big ? (LAST_BYTE - lane) : lane;
        lane_select = {{(DATA_W-BYTE_W){1'b0}}, word[idx*BYTE_W +: BYTE_W]};
      end
      WIDTH_WORD: begin
        idx = {1'b0, big ? ~lane[0] : lane[0]};
        lane_select = {{(DATA_W-WORD_W){1'b0}}, word[idx[0]*WORD_W +: WORD_W]};
      end
      default: begin
        lane_select = word;
      end
    endcase
  endfunction : lane_select

  // words written by port A are kept here
  always_ff @(posedge mclk_in) begin
    if (wr_en) begin
      mem_q[q.wr_ptr] <= a_sync[A_DATA +: DATA_W];
    end
  end

  always_comb begin
    logic       a_edge;
    logic       b_edge;
    logic       a_req;
    logic       b_req;
    logic       fall_through_mode;
    logic       push;
    logic       pop;
    logic       lane_done;
    logic [1:0] last;
    a_edge    = 1'b0;
    b_edge    = 1'b0;
    a_req     = 1'b0;
    b_req     = 1'b0;
    fall_through_mode      = 1'b0;
    push      = 1'b0;
    pop       = 1'b0;
    lane_done = 1'b0;
    last      = LAST_LONG;
    d         = q;
    wr_en     = 1'b0;

    // rising edges of the port clocks become one-cycle enables
    d.a_clk_prev = a_sync[A_CLK];
    d.b_clk_prev = b_sync[B_CLK];
    a_edge = a_sync[A_CLK] & ~q.a_clk_prev;
    b_edge = b_sync[B_CLK] & ~q.b_clk_prev;
    a_req  = a_edge & ~a_sync[A_SEL_N] & a_sync[A_EN];
    b_req  = b_edge & ~b_sync[B_SEL_N] & b_sync[B_QUAL] & b_sync[B_RD];
    fall_through_mode   = ~c_sync[C_ETS];

    case (q.width)
      WIDTH_BYTE: last = LAST_BYTE;
      WIDTH_WORD: last = LAST_WORD;
      default:    last = LAST_LONG;
    endcase

    // configuration is caught once the strap levels have settled
    case (q.cfg)
      CFG_CAPTURE: begin
        d.wait_cnt = q.wait_cnt + 3'h1;
        if (q.wait_cnt == CAPTURE_WAIT) begin
          d.big_endian = c_sync[C_ETS];
          if (!c_sync[C_BM]) begin
            d.width = WIDTH_LONG;
          end else if (c_sync[C_SIZE]) begin
            d.width = WIDTH_BYTE;
          end else begin
            d.width = WIDTH_WORD;
          end
          if (!c_sync[C_SPM_N]) begin
            d.cfg = CFG_SERIAL;
          end else begin
            case ({c_sync[C_FS1], c_sync[C_FS0]})
              FS_8: begin
                d.low_thr  = PRESET_8;
                d.high_thr = PRESET_8;
                d.cfg      = CFG_READY;
              end
              FS_16: begin
                d.low_thr  = PRESET_16;
                d.high_thr = PRESET_16;
                d.cfg      = CFG_READY;
              end
              FS_64: begin
                d.low_thr  = PRESET_64;
                d.high_thr = PRESET_64;
                d.cfg      = CFG_READY;
              end
              default: begin
                d.cfg = CFG_PARALLEL;
              end
            endcase
          end
        end
      end
      CFG_SERIAL: begin
        // first bit lands in the upper offset msb, last in the lower lsb
        if (a_edge && !c_sync[C_FS1]) begin
          {d.high_thr, d.low_thr} = {q.high_thr[PTR_W-2:0], q.low_thr, c_sync[C_FS0]};
          d.serial_cnt = q.serial_cnt + 5'h01;
          if (q.serial_cnt == SERIAL_BITS - 5'h01) begin
            d.cfg = CFG_READY;
          end
        end
      end
      CFG_PARALLEL: begin
        // two port A writes: lower offset, then upper offset
        if (a_req && a_sync[A_WR]) begin
          if (!q.par_second) begin
            d.low_thr    = a_sync[A_DATA +: PTR_W];
            d.par_second = 1'b1;
          end else begin
            d.high_thr = a_sync[A_DATA +: PTR_W];
            d.cfg      = CFG_READY;
          end
        end
      end
      default: begin
        d.cfg = CFG_READY;
      end
    endcase

    // port A write into memory when space remains
    if (q.cfg == CFG_READY && a_req && a_sync[A_WR] && q.mem_cnt != DEPTH_COUNT) begin
      push     = 1'b1;
      wr_en    = 1'b1;
      d.wr_ptr = q.wr_ptr + 8'h01;
    end

    // port B read, lane by lane across one stored word
    if (!fall_through_mode) begin
      if (b_req && q.mem_cnt != '0) begin
        d.b_bus = lane_select(mem_q[q.rd_ptr], q.width, q.big_endian, q.lane);
        if (q.lane == last) begin
          d.lane   = 2'h0;
          d.rd_ptr = q.rd_ptr + 8'h01;
          pop      = 1'b1;
        end else begin
          d.lane = q.lane + 2'h1;
        end
      end
      d.staged = 1'b0;
    end else begin
      if (b_req && q.staged) begin
        if (q.lane == last) begin
          lane_done = 1'b1;
          d.lane    = 2'h0;
        end else begin
          d.lane = q.lane + 2'h1;
        end
      end
      if (b_edge && (!q.staged || lane_done) && q.mem_cnt != '0) begin
        d.stage_word = mem_q[q.rd_ptr];
        d.rd_ptr     = q.rd_ptr + 8'h01;
        d.lane       = 2'h0;
        d.staged     = 1'b1;
        pop          = 1'b1;
      end else if (lane_done) begin
        d.staged = 1'b0;
      end
      d.b_bus = lane_select(d.stage_word, q.width, q.big_endian, d.lane);
    end

    case ({push, pop})
      2'b10:   d.mem_cnt = q.mem_cnt + 9'h001;
      2'b01:   d.mem_cnt = q.mem_cnt - 9'h001;
      default: d.mem_cnt = q.mem_cnt;
    endcase

    // levels seen by the almost flags
    stored_level = d.mem_cnt + {{(CNT_W-1){1'b0}}, fall_through_mode & d.staged};
    free_level   = DEPTH_COUNT - d.mem_cnt;

    // port B flags move only on port B clock edges
    if (b_edge) begin
      d.ef = fall_through_mode ? d.staged : (d.mem_cnt != '0);
      d.ae = ~low_hit;
    end
    // port A flags move only on port A clock edges
    if (a_edge) begin
      d.ff = (q.cfg == CFG_READY) && (d.mem_cnt != DEPTH_COUNT);
      d.af = ~high_hit;
    end

    // port A driver on once the capture wait ends; both drivers only while selected for a read
    d.a_oe  = (q.cfg != CFG_CAPTURE) & ~a_sync[A_SEL_N] & ~a_sync[A_WR];
    d.a_bus = '0;
    d.b_oe  = ~b_sync[B_SEL_N] & b_sync[B_RD];
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      q            <= '0;
      q.cfg        <= CFG_CAPTURE;
      q.width      <= WIDTH_LONG;
      q.low_thr    <= THR_RESET;
      q.high_thr   <= THR_RESET;
      q.af         <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // outputs come straight from the state register
  assign port_a_bus_out        = q.a_bus;
  assign port_a_bus_oe_out     = q.a_oe;
  assign port_b_bus_out        = q.b_bus;
  assign port_b_bus_oe_out     = q.b_oe;
  assign empty_ready_flag_out  = q.ef;
  assign full_space_flag_out   = q.ff;
  assign almost_empty_flag_out = q.ae;
  assign almost_full_flag_out  = q.af;
endmodule : bus_matching_fifo

// [bus_matching_fifo_checker.sv]
`timescale 1ns/1ns
module bus_matching_fifo_checker
  import fifo_pkg::*;
(
  input wire logic              mclk_in,
  input wire logic              rstn_in,
  input wire logic              port_a_clock_in,
  input wire logic              port_a_select_n_in,
  input wire logic              port_a_bus_oe_out,
  input wire logic              port_b_clock_in,
  input wire logic              port_b_select_n_in,
  input wire logic [DATA_W-1:0] port_b_bus_out,
  input wire logic              port_b_bus_oe_out,
  input wire logic              bus_match_select_in,
  input wire logic              size_select_in,
  input wire logic              empty_ready_flag_out,
  input wire logic              full_space_flag_out,
  input wire logic              almost_empty_flag_out,
  input wire logic              almost_full_flag_out
);
  logic       a_prev_q;
  logic       b_prev_q;
  logic [3:0] a_age_q;
  logic [3:0] b_age_q;

  // cycles since each port clock pin was seen rising, saturating
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      a_prev_q <= 1'h0;
      b_prev_q <= 1'h0;
      a_age_q  <= 4'hF;
      b_age_q  <= 4'hF;
    end else begin
      a_prev_q <= port_a_clock_in;
      b_prev_q <= port_b_clock_in;
      a_age_q  <= (port_a_clock_in & ~a_prev_q) ? 4'h0 : a_age_q + {3'h0, a_age_q != 4'hF};
      b_age_q  <= (port_b_clock_in & ~b_prev_q) ? 4'h0 : b_age_q + {3'h0, b_age_q != 4'hF};
    end
  end

  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);

  // a select held high long enough to pass the pin synchroniser
  sequence a_idle_s;
    port_a_select_n_in [*6];
  endsequence
  sequence b_idle_s;
    port_b_select_n_in [*6];
  endsequence

  a_pa_released: assert property (a_idle_s |-> !port_a_bus_oe_out)
    else $error("port A bus driven while deselected");
  a_pb_released: assert property (b_idle_s |-> !port_b_bus_oe_out)
    else $error("port B bus driven while deselected");
  a_ae_b_timed: assert property ($changed(almost_empty_flag_out) |-> b_age_q inside {[4'h1:4'h8]})
    else $error("almost empty moved without a port B edge");
  a_ef_b_timed: assert property ($changed(empty_ready_flag_out) |-> b_age_q inside {[4'h1:4'h8]})
    else $error("empty ready moved without a port B edge");
  a_ff_a_timed: assert property ($changed(full_space_flag_out) |-> a_age_q inside {[4'h1:4'h8]})
    else $error("space flag moved without a port A edge");
  a_af_a_timed: assert property ($changed(almost_full_flag_out) |-> a_age_q inside {[4'h1:4'h8]})
    else $error("almost full moved without a port A edge");
  a_full_sets_af: assert property ($fell(full_space_flag_out) |-> !almost_full_flag_out)
    else $error("full without almost full");
  a_empty_clears_ae: assert property ($fell(empty_ready_flag_out) |-> !almost_empty_flag_out)
    else $error("empty without almost empty");
  a_byte_lanes: assert property (bus_match_select_in && size_select_in |-> port_b_bus_out[35:9] == 27'h0)
    else $error("byte bus upper bits set");
  a_word_lanes: assert property (bus_match_select_in && !size_select_in |-> port_b_bus_out[35:18] == 18'h0)
    else $error("word bus upper bits set");
endmodule : bus_matching_fifo_checker

bind bus_matching_fifo bus_matching_fifo_checker u_checker (
  .mclk_in(mclk_in), .rstn_in(rstn_in), .port_a_clock_in(port_a_clock_in),
  .port_a_select_n_in(port_a_select_n_in), .port_a_bus_oe_out(port_a_bus_oe_out),
  .port_b_clock_in(port_b_clock_in), .port_b_select_n_in(port_b_select_n_in),
  .port_b_bus_out(port_b_bus_out), .port_b_bus_oe_out(port_b_bus_oe_out),
  .bus_match_select_in(bus_match_select_in), .size_select_in(size_select_in),
  .empty_ready_flag_out(empty_ready_flag_out), .full_space_flag_out(full_space_flag_out),
  .almost_empty_flag_out(almost_empty_flag_out), .almost_full_flag_out(almost_full_flag_out)
);

// [port_b_reader.sv]
`timescale 1ns/1ns
module port_b_reader (
  input  wire logic        mclk_in,
  input  wire logic        read_req_in,
  output logic             port_b_clock_out,
  output logic             port_b_select_n_out,
  output logic             port_b_qualifier_out,
  output logic             port_b_read_out,
  output logic      [35:0] port_b_data_out
);
  logic [3:0] phase_q = 4'h0;

  // free-running port clock, twelve system cycles a period
  assign port_b_clock_out = (phase_q < 4'h6);

  // controls move only at the port clock falling edge
  always @(posedge mclk_in) begin
    phase_q <= (phase_q == 4'hB) ? 4'h0 : phase_q + 4'h1;
    if (phase_q == 4'h5) begin
      port_b_select_n_out  <= ~read_req_in;
      port_b_qualifier_out <= read_req_in;
      port_b_read_out      <= read_req_in;
    end
    port_b_data_out <= ~port_b_data_out; // unselected lines never hold a value
  end

  initial begin
    port_b_select_n_out  = 1'h1;
    port_b_qualifier_out = 1'h0;
    port_b_read_out      = 1'h0;
    port_b_data_out      = 36'h0;
  end
endmodule : port_b_reader

// [tb_bus_matching_fifo.sv]
`timescale 1ns/1ns
module tb_bus_matching_fifo;
  import fifo_pkg::*;
  localparam int LIMIT = 90000;
  logic        mclk, rstn, pa_clk, pa_sel_n, pa_en, pa_wr, ets, bm, size, rd_req, fall_through_mode, spm_n;
  logic [1:0]  fs;
  logic [35:0] pa_data;
  wire  [35:0] pa_out, pb_out, pb_data;
  wire         pa_oe, pb_oe, pb_clk, pb_sel_n, pb_qual, pb_rd, ef, ff, ae, af;
  int          mismatches, checks, cycles, seed, off, off_hi, lanes;
  logic [35:0] words[$];

  bus_matching_fifo u_dut (
    .mclk_in(mclk), .rstn_in(rstn), .port_a_clock_in(pa_clk), .port_a_select_n_in(pa_sel_n),
    .port_a_enable_in(pa_en), .port_a_write_in(pa_wr), .port_a_bus_in(pa_data),
    .port_a_bus_out(pa_out), .port_a_bus_oe_out(pa_oe), .port_b_clock_in(pb_clk),
    .port_b_select_n_in(pb_sel_n), .port_b_qualifier_in(pb_qual), .port_b_read_in(pb_rd),
    .port_b_bus_in(pb_data), .port_b_bus_out(pb_out), .port_b_bus_oe_out(pb_oe),
    .endian_timing_select_in(ets), .bus_match_select_in(bm), .size_select_in(size),
    .serial_mode_n_in(spm_n), .flag_select_in(fs), .empty_ready_flag_out(ef),
    .full_space_flag_out(ff), .almost_empty_flag_out(ae), .almost_full_flag_out(af)
  );

  port_b_reader u_reader (
    .mclk_in(mclk), .read_req_in(rd_req), .port_b_clock_out(pb_clk),
    .port_b_select_n_out(pb_sel_n), .port_b_qualifier_out(pb_qual),
    .port_b_read_out(pb_rd), .port_b_data_out(pb_data)
  );

  // clocks: system clock and a slower port A clock
  initial begin
    mclk = 1'h0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    pa_clk = 1'h0;
    forever begin
      repeat (6) @(negedge mclk);
      pa_clk = ~pa_clk;
    end
  end

  // hang guard
  always @(posedge mclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      complete_run();
    end
  end

  // lane k of a stored word as port B should present it
  function automatic logic [35:0] exp_lane(input logic [35:0] w, input int k);
    int          lw;
    int          idx;
    logic [35:0] m;
    lw  = 36 / lanes;
    idx = ets ? lanes - 1 - k : k;
    m   = (36'h1 << lw) - 36'h1;
    return (w >> (idx * lw)) & m;
  endfunction : exp_lane

  task automatic cmp_data(input string what, input logic [35:0] exp, input logic [35:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_data

  task automatic cmp_flag(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask : cmp_flag

  // one port A cycle held across a port clock rising edge
  task automatic a_write(input logic [35:0] d, input logic sel_n, input logic en);
    @(negedge pa_clk);
    pa_sel_n = sel_n;
    pa_en    = en;
    pa_wr    = 1'h1;
    pa_data  = d;
    @(negedge pa_clk);
    pa_sel_n = 1'h1;
    pa_en    = 1'h0;
    pa_wr    = 1'h0;
    repeat (5) @(negedge mclk);
  endtask : a_write

  // one read through the partner, then let the answer settle
  task automatic b_read;
    rd_req = 1'h1;
    do @(posedge pb_clk); while (pb_rd !== 1'h1);
    @(negedge mclk);
    cmp_flag("port B drive", 1'h1, pb_oe);
    rd_req = 1'h0;
    repeat (9) @(negedge mclk);
  endtask : b_read

  // how: 0 preset offsets, 1 parallel load on port A, 2 serial load
  task automatic run_config(input logic e, input logic m, input logic s, input int how);
    logic [35:0] w;
    logic [15:0] sbits;
    int          rem;
    rstn   = 1'h0;
    ets    = e;
    bm     = m;
    size   = s;
    spm_n  = (how != 2);
    fs     = (how == 0) ? 2'($unsigned($random(seed)) % 3 + 1) : {how == 2, 1'h0};
    off    = (fs == 2'h1) ? 8 : (fs == 2'h2) ? 16 : 64;
    if (how != 0) off = $unsigned($random(seed)) % 256;
    off_hi = (how != 0) ? $unsigned($random(seed)) % 255 : off;
    sbits  = {8'(off_hi), 8'(off)};
    fall_through_mode = !e;
    lanes = !m ? 1 : (s ? 4 : 2);
    words.delete();
    repeat (10) @(negedge mclk);
    rstn = 1'h1;
    repeat (12) @(negedge mclk);
    // offsets: lower then upper by port A, or sixteen bits, upper msb first
    if (how == 1) begin
      a_write(36'(off), 1'h0, 1'h1);
      a_write(36'(off_hi), 1'h0, 1'h1);
    end
    if (how == 2) begin
      for (int b = 15; b >= 0; b--) begin
        @(negedge pa_clk);
        fs = {1'h0, sbits[b]};
      end
      @(negedge pa_clk);
      fs = 2'h2;
    end
    a_write(36'hF_FFFF_FFFF, 1'h1, 1'h1);
    a_write(36'hA_AAAA_AAAA, 1'h0, 1'h0);
    for (int i = 0; i < 257; i++) begin
      w = (i == 0) ? 36'h8_0000_0001 : 36'({$random(seed), $random(seed)});
      a_write(w, 1'h0, 1'h1);
      // fall-through holds one word more, in the output stage
      if (i < 256 + int'(fall_through_mode)) words.push_back(w);
      rem = (i < 256) ? 255 - i + int'(fall_through_mode) : 0;
      cmp_flag("space flag", rem != 0, ff);
      cmp_flag("almost full", rem > off_hi, af);
    end
    cmp_flag("empty ready", 1'h1, ef);
    cmp_flag("port A drive", 1'h0, pa_oe);
    cmp_data("port A bus", 36'h0, pa_out);
    cmp_flag("port B drive", 1'h0, pb_oe);
    rem = words.size();
    foreach (words[j]) begin
      for (int k = 0; k < lanes; k++) begin
        if (fall_through_mode) cmp_data("ready lane", exp_lane(words[j], k), pb_out);
        b_read();
        if (!fall_through_mode) cmp_data("read lane", exp_lane(words[j], k), pb_out);
      end
      rem--;
      cmp_flag("almost empty", rem > off, ae);
      cmp_flag("empty ready", rem != 0, ef);
    end
    b_read();
    cmp_flag("empty ready", 1'h0, ef);
    if (!fall_through_mode) cmp_data("held lane", exp_lane(words[255], lanes - 1), pb_out);
  endtask : run_config

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  initial begin
    seed = 32'h81AD29F2;
    mismatches = 0;
    checks = 0;
    cycles = 0;
    rstn = 1'h0;
    pa_sel_n = 1'h1;
    pa_en = 1'h0;
    pa_wr = 1'h0;
    pa_data = 36'h0;
    rd_req = 1'h0;
    ets = 1'h1;
    bm = 1'h0;
    size = 1'h0;
    fs = 2'h1;
    spm_n = 1'h1;
    fall_through_mode = 1'h0;
    lanes = 1;
    @(negedge mclk);
    run_config(1'h1, 1'h1, 1'h1, 0);
    run_config(1'h0, 1'h1, 1'h0, 1);
    run_config(1'h1, 1'h0, 1'h0, 2);
    complete_run();
  end
endmodule : tb_bus_matching_fifo
